// *** rtl/svc_cmd_pkg.sv ***
package svc_cmd_pkg;

  // Characters seen on the command link
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_X = 8'h78;
  localparam logic [7:0] CH_Z = 8'h7A;
  localparam logic [7:0] CH_S = 8'h73;
  localparam logic [7:0] CH_LN = 8'h6E;
  localparam logic [7:0] CH_LI = 8'h69;
  localparam logic [7:0] CH_UN = 8'h4E;
  localparam logic [7:0] CH_UI = 8'h49;
  localparam logic [7:0] CH_UY = 8'h59;

  // Hold time before an exit to a lower-case target (n or i)
  localparam int HOLD_MS = 3000;
  localparam int CLK_KHZ = 25000;
  localparam int HOLD_CYCLES = HOLD_MS * CLK_KHZ;

  // Flash wear limit
  localparam logic [15:0] SAVE_LIMIT = 16'h03E8;
  localparam logic [15:0] SAVE_ONE = 16'h0001;

  // Message codes sent to the text formatter
  typedef enum logic [4:0] {
    MSG_PROMPT = 5'h00,
    MSG_E001 = 5'h01,
    MSG_E002 = 5'h02,
    MSG_E003 = 5'h03,
    MSG_E004 = 5'h04,
    MSG_E005 = 5'h05,
    MSG_ASK_EXIT = 5'h06,
    MSG_RET_NORMAL = 5'h07,
    MSG_RET_INIT = 5'h08,
    MSG_ASK_RESTORE = 5'h09,
    MSG_ASK_XMIT = 5'h0A,
    MSG_APPLIED = 5'h0B,
    MSG_APPLIED_SAVED = 5'h0C,
    MSG_ABORTED = 5'h0D
  } msg_t;

  // Mode requests towards the mode controller
  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_NORMAL = 2'b01,
    MODE_INIT = 2'b10
  } mode_req_t;

endpackage : svc_cmd_pkg

// *** rtl/flash_save_if.sv ***
`timescale 1ns/1ps
interface flash_save_if;
  logic start;
  logic done;
  logic ok;
  logic [15:0] count;
  logic over_limit;
  modport ctl (output start, input done, input ok, input count, input over_limit);
  modport agent (input start, output done, output ok, output count, output over_limit);
endinterface : flash_save_if

// *** rtl/hold_timer.sv ***
`timescale 1ns/1ps
module hold_timer #(
  parameter int HOLD = 75000000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  output logic expired
);
  logic [31:0] cnt_q;
  logic run_q;

  // Down counter, one-cycle expiry pulse
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cnt_q <= 32'h0;
      run_q <= 1'b0;
      expired <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (start)
      begin
        cnt_q <= 32'(HOLD - 1);
        run_q <= 1'b1;
      end
      else if (run_q)
      begin
        if (cnt_q == 32'h0)
        begin
          run_q <= 1'b0;
          expired <= 1'b1;
        end
        else
          cnt_q <= cnt_q - 32'h1;
      end
    end
  end
endmodule : hold_timer

// *** rtl/save_agent.sv ***
`timescale 1ns/1ps
module save_agent (
  input wire logic clk,
  input wire logic resetn,
  flash_save_if.agent fs,
  output logic flash_wr,
  input wire logic flash_ack,
  input wire logic flash_err,
  input wire logic [15:0] save_count_init
);
  import svc_cmd_pkg::*;
  logic busy_q;
  logic [15:0] count_q;
  logic loaded_q;
  logic over_q;

  // Limit judged on the count before this save, held until the next one
  assign fs.count = count_q;
  assign fs.over_limit = over_q;

  // Counter loaded from persistent store after reset release
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      busy_q <= 1'b0;
      count_q <= 16'h0;
      loaded_q <= 1'b0;
      over_q <= 1'b0;
      flash_wr <= 1'b0;
      fs.done <= 1'b0;
      fs.ok <= 1'b0;
    end
    else
    begin
      fs.done <= 1'b0;
      flash_wr <= 1'b0;
      if (!loaded_q)
      begin
        count_q <= save_count_init;
        loaded_q <= 1'b1;
      end
      if (fs.start && !busy_q)
      begin
        busy_q <= 1'b1;
        flash_wr <= 1'b1;
        over_q <= (count_q > SAVE_LIMIT);
      end
      else if (busy_q && (flash_ack || flash_err))
      begin
        busy_q <= 1'b0;
        fs.done <= 1'b1;
        fs.ok <= flash_ack && !flash_err;
        count_q <= count_q + SAVE_ONE; // Every attempt wears the flash
      end
    end
  end
endmodule : save_agent

// *** rtl/svc_exit_restore.sv ***
`timescale 1ns/1ps
module svc_exit_restore #(
  parameter int HOLD = svc_cmd_pkg::HOLD_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  input wire logic msg_ready,
  output logic msg_valid,
  output svc_cmd_pkg::msg_t msg_code,
  output logic [15:0] msg_count,
  input wire logic param_changed,
  input wire logic xmit_differs,
  output logic params_dirty,
  output logic load_factory,
  output logic reload_flash,
  output svc_cmd_pkg::mode_req_t mode_req,
  output logic flash_wr,
  input wire logic flash_ack,
  input wire logic flash_err,
  input wire logic [15:0] save_count_init
);
  import svc_cmd_pkg::*;

  typedef enum logic [3:0] {
    ST_CMD = 4'b0000,
    ST_ARG = 4'b0001,
    ST_ARG_CR = 4'b0010,
    ST_ASK = 4'b0011,
    ST_ANS = 4'b0100,
    ST_ANS_CR = 4'b0101,
    ST_HOLD = 4'b0110,
    ST_SAVE = 4'b0111,
    ST_EMIT = 4'b1000,
    ST_SKIP = 4'b1001
  } state_t;

  typedef enum logic [1:0] {
    CMD_EXIT = 2'b00,
    CMD_RESTORE = 2'b01
  } cmd_t;

  state_t state_q;
  cmd_t cmd_q;
  logic [7:0] arg_q;
  logic [7:0] ans_q;
  logic stage2_q;
  logic save_opt_q;
  logic bad_q;
  logic hold_start;
  logic hold_done;
  msg_t q_msg [0:3];
  logic [2:0] q_len_q;
  logic [1:0] q_idx_q;
  state_t after_q;
  logic [1:0] push_n;
  msg_t push_a;
  msg_t push_b;
  msg_t push_c;

  flash_save_if fs();

  hold_timer #(.HOLD(HOLD)) u_hold (
    .clk(clk),
    .resetn(resetn),
    .start(hold_start),
    .expired(hold_done)
  );

  save_agent u_save (
    .clk(clk),
    .resetn(resetn),
    .fs(fs),
    .flash_wr(flash_wr),
    .flash_ack(flash_ack),
    .flash_err(flash_err),
    .save_count_init(save_count_init)
  );

  // Exit target legal and needing the hold; confirmation only when dirty
  function automatic logic is_slow_target(input logic [7:0] c);
    is_slow_target = (c == CH_LN) || (c == CH_LI);
  endfunction : is_slow_target

  function automatic logic is_fast_target(input logic [7:0] c);
    is_fast_target = (c == CH_UN) || (c == CH_UI);
  endfunction : is_fast_target

  wire rx_cr = rx_valid && (rx_char == CH_CR);
  wire emitting = (state_q == ST_EMIT);

  assign hold_start = (state_q == ST_EMIT) && (q_idx_q == 2'(q_len_q - 3'h1)) && msg_ready
                      && (after_q == ST_HOLD);

  // Message sequencer: queued codes go out one by one with handshake
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      msg_valid <= 1'b0;
      msg_code <= MSG_PROMPT;
      msg_count <= 16'h0;
      q_idx_q <= 2'h0;
    end
    else if (emitting)
    begin
      msg_valid <= 1'b1;
      msg_code <= q_msg[q_idx_q];
      msg_count <= fs.count;
      if (msg_valid && msg_ready)
      begin
        msg_valid <= 1'b0;
        q_idx_q <= q_idx_q + 2'h1;
      end
    end
    else
    begin
      msg_valid <= 1'b0;
      q_idx_q <= 2'h0;
    end
  end

  // Dirty flag: change sets, save or reload clears; set wins
  always_ff @(posedge clk)
  begin
    if (!resetn)
      params_dirty <= 1'b0;
    else if (param_changed)
      params_dirty <= 1'b1;
    else if (reload_flash || (fs.done && fs.ok))
      params_dirty <= 1'b0;
    else if (load_factory && !save_opt_q)
      params_dirty <= 1'b1;
  end

  // Queue loader defaults, unused; each decision writes q_msg directly
  always_comb
  begin
    push_n = 2'h0;
    push_a = MSG_PROMPT;
    push_b = MSG_PROMPT;
    push_c = MSG_PROMPT;
  end

  // Command interpreter
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_q <= ST_CMD;
      cmd_q <= CMD_EXIT;
      arg_q <= 8'h00;
      ans_q <= 8'h00;
      stage2_q <= 1'b0;
      save_opt_q <= 1'b0;
      bad_q <= 1'b0;
      q_len_q <= 3'h0;
      after_q <= ST_CMD;
      load_factory <= 1'b0;
      reload_flash <= 1'b0;
      mode_req <= MODE_NONE;
      fs.start <= 1'b0;
      for (int k = 0; k < 4; k++)
        q_msg[k] <= MSG_PROMPT;
    end
    else
    begin
      load_factory <= 1'b0;
      reload_flash <= 1'b0;
      mode_req <= MODE_NONE;
      fs.start <= 1'b0;
      case (state_q)
        ST_CMD:
        begin
          bad_q <= 1'b0;
          save_opt_q <= 1'b0;
          stage2_q <= 1'b0;
          arg_q <= 8'h00;
          if (rx_valid)
          begin
            if (rx_char == CH_X)
            begin
              cmd_q <= CMD_EXIT;
              state_q <= ST_ARG;
            end
            else if (rx_char == CH_Z)
            begin
              cmd_q <= CMD_RESTORE;
              state_q <= ST_ARG;
            end
            else if (rx_char != CH_CR)
            begin
              q_msg[0] <= MSG_E001;
              q_msg[1] <= MSG_PROMPT;
              q_len_q <= 3'h2;
              after_q <= ST_CMD;
              state_q <= ST_SKIP;
            end
          end
        end
        ST_SKIP:
        begin
          if (rx_cr)
            state_q <= ST_EMIT;
        end
        ST_ARG:
        begin
          // Gather up to space-argument; anything else marks count error
          if (rx_cr)
          begin
            state_q <= ST_ARG_CR;
          end
          else if (rx_valid)
          begin
            if (rx_char == CH_SP || (rx_char == CH_COMMA && cmd_q == CMD_RESTORE && arg_q == CH_SP))
              arg_q <= (arg_q == 8'h00) ? CH_SP : arg_q;
            else if (rx_char == CH_COMMA)
              bad_q <= 1'b1;
            else if (arg_q == CH_SP)
              arg_q <= rx_char;
            else
              bad_q <= 1'b1;
          end
        end
        ST_ARG_CR:
        begin
          after_q <= ST_CMD;
          q_len_q <= 3'h2;
          q_msg[1] <= MSG_PROMPT;
          if (cmd_q == CMD_EXIT)
          begin
            if (bad_q || arg_q == 8'h00 || arg_q == CH_SP)
            begin
              q_msg[0] <= MSG_E002;
              state_q <= ST_EMIT;
            end
            else if (is_fast_target(arg_q))
            begin
              mode_req <= (arg_q == CH_UN) ? MODE_NORMAL : MODE_INIT;
              reload_flash <= (arg_q == CH_UI);
              state_q <= ST_CMD;
            end
            else if (!is_slow_target(arg_q))
            begin
              q_msg[0] <= MSG_E003;
              state_q <= ST_EMIT;
            end
            else if (params_dirty)
            begin
              q_msg[0] <= MSG_ASK_EXIT;
              q_len_q <= 3'h1;
              after_q <= ST_ANS;
              state_q <= ST_EMIT;
            end
            else
            begin
              q_msg[0] <= (arg_q == CH_LN) ? MSG_RET_NORMAL : MSG_RET_INIT;
              q_len_q <= 3'h1;
              after_q <= ST_HOLD;
              state_q <= ST_EMIT;
            end
          end
          else
          begin
            if (bad_q || arg_q == CH_SP || (arg_q != 8'h00 && arg_q != CH_S))
            begin
              q_msg[0] <= MSG_E002;
              state_q <= ST_EMIT;
            end
            else
            begin
              save_opt_q <= (arg_q == CH_S);
              q_msg[0] <= MSG_ASK_RESTORE;
              q_len_q <= 3'h1;
              after_q <= ST_ANS;
              state_q <= ST_EMIT;
            end
          end
        end
        ST_EMIT:
        begin
          if (msg_valid && msg_ready && (q_idx_q == 2'(q_len_q - 3'h1)))
          begin
            state_q <= after_q;
            ans_q <= 8'h00;
          end
        end
        ST_ANS:
        begin
          if (rx_cr)
            state_q <= ST_ANS_CR;
          else if (rx_valid && ans_q == 8'h00)
            ans_q <= rx_char;
          else if (rx_valid)
            ans_q <= 8'hFF; // Extra characters spoil the answer
        end
        ST_ANS_CR:
        begin
          q_len_q <= 3'h1;
          q_msg[0] <= MSG_PROMPT;
          after_q <= ST_CMD;
          state_q <= ST_EMIT;
          if (ans_q == CH_UN)
          begin
            q_msg[0] <= (cmd_q == CMD_RESTORE) ? MSG_ABORTED : MSG_PROMPT;
            q_msg[1] <= MSG_PROMPT;
            q_len_q <= (cmd_q == CMD_RESTORE) ? 3'h2 : 3'h1;
          end
          else if (ans_q != CH_UY)
          begin
            q_msg[0] <= MSG_E003;
            q_msg[1] <= MSG_PROMPT;
            q_len_q <= 3'h2;
          end
          else if (cmd_q == CMD_EXIT)
          begin
            q_msg[0] <= (arg_q == CH_LN) ? MSG_RET_NORMAL : MSG_RET_INIT;
            after_q <= ST_HOLD;
          end
          else if (xmit_differs && !stage2_q)
          begin
            stage2_q <= 1'b1;
            q_msg[0] <= MSG_ASK_XMIT;
            after_q <= ST_ANS;
          end
          else
          begin
            load_factory <= 1'b1;
            if (save_opt_q)
            begin
              fs.start <= 1'b1;
              state_q <= ST_SAVE;
            end
            else
            begin
              q_msg[0] <= MSG_APPLIED;
              q_msg[1] <= MSG_PROMPT;
              q_len_q <= 3'h2;
            end
          end
        end
        ST_SAVE:
        begin
          if (fs.done)
          begin
            q_msg[0] <= fs.ok ? MSG_APPLIED_SAVED : MSG_E005;
            q_msg[1] <= fs.over_limit ? MSG_E004 : MSG_PROMPT;
            q_msg[2] <= MSG_PROMPT;
            q_len_q <= fs.over_limit ? 3'h3 : 3'h2;
            after_q <= ST_CMD;
            state_q <= ST_EMIT;
          end
        end
        ST_HOLD:
        begin
          if (hold_done)
          begin
            mode_req <= (arg_q == CH_LN) ? MODE_NORMAL : MODE_INIT;
            reload_flash <= (arg_q == CH_LI);
            state_q <= ST_CMD;
          end
        end
        default:
          state_q <= ST_CMD;
      endcase
    end
  end
endmodule : svc_exit_restore

// *** verif/host_term_model.sv ***
`timescale 1ns/1ps
// Host terminal and flash stand-in beyond the interpreter
module host_term_model
  import svc_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic msg_valid,
  input wire svc_cmd_pkg::msg_t msg_code,
  input wire logic flash_wr,
  input wire logic slow,
  input wire logic fail,
  output logic msg_ready,
  output logic flash_ack,
  output logic flash_err
);
  msg_t got_q[$];
  logic [2:0] fl_q;
  initial
  begin
    msg_ready = 1'b0;
    flash_ack = 1'b0;
    flash_err = 1'b0;
    fl_q = 3'h0;
  end
  // Slow host takes every other cycle, so messages must stand
  always @(posedge clk)
  begin
    msg_ready <= slow ? !msg_ready : 1'b1;
    if (msg_valid && msg_ready)
      got_q.push_back(msg_code);
  end
  // Flash finishes four cycles after a write starts
  always @(posedge clk)
  begin
    fl_q <= flash_wr ? 3'h3 : (fl_q != 3'h0 ? fl_q - 3'h1 : 3'h0);
    flash_ack <= (fl_q == 3'h1) && !fail;
    flash_err <= (fl_q == 3'h1) && fail;
  end
endmodule : host_term_model

// *** verif/svc_exit_restore_sva.sv ***
`timescale 1ns/1ps
// Port-level checks on the exit and restore interpreter
module svc_exit_restore_sva
  import svc_cmd_pkg::*;
#(
  parameter int HOLD = 20
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  input wire logic msg_ready,
  input wire logic msg_valid,
  input wire svc_cmd_pkg::msg_t msg_code,
  input wire logic [15:0] msg_count,
  input wire logic param_changed,
  input wire logic xmit_differs,
  input wire logic params_dirty,
  input wire logic load_factory,
  input wire logic reload_flash,
  input wire svc_cmd_pkg::mode_req_t mode_req,
  input wire logic flash_wr,
  input wire logic flash_ack,
  input wire logic flash_err,
  input wire logic [15:0] save_count_init
);
  logic rl_q;
  // Reload may lead the init request by a cycle
  always_ff @(posedge clk)
  begin
    rl_q <= resetn && reload_flash;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_reset_quiet: assert property (@(posedge clk) disable iff (1'b0)
    !resetn |=> !msg_valid && mode_req == MODE_NONE && !flash_wr) else $error("reset leak");
  a_msg_stands: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_code))
    else $error("message dropped");
  a_load_pulse: assert property (load_factory |=> !load_factory) else $error("load");
  a_wr_pulse: assert property (flash_wr |=> !flash_wr) else $error("flash write");
  a_mode_pulse: assert property (mode_req != MODE_NONE |=> mode_req == MODE_NONE)
    else $error("mode request");
  a_init_reload: assert property (mode_req == MODE_INIT |->
    (reload_flash || rl_q) or (##1 reload_flash)) else $error("init without reload");
  a_dirty_set: assert property (param_changed |=> params_dirty) else $error("dirty");
  a_save_loads: assert property (flash_wr |-> load_factory || $past(load_factory)
    || $past(load_factory, 2)) else $error("save without load");
  a_save_report: assert property (flash_ack |-> ##[1:8] msg_valid
    && msg_code == MSG_APPLIED_SAVED) else $error("save report");
  a_save_fail: assert property (flash_err |-> ##[1:8] msg_valid && msg_code == MSG_E005)
    else $error("save failure");
  a_save_clean: assert property (flash_ack |-> ##[1:4] !params_dirty) else $error("clean");
  c_normal: cover property (mode_req == MODE_NORMAL);
  c_init: cover property (mode_req == MODE_INIT);
  c_saved: cover property (msg_valid && msg_ready && msg_code == MSG_APPLIED_SAVED);
  c_stall: cover property (msg_valid && !msg_ready);
endmodule : svc_exit_restore_sva

bind svc_exit_restore svc_exit_restore_sva #(.HOLD(HOLD)) i_svc_exit_restore_sva (
  .clk(clk), .resetn(resetn), .rx_valid(rx_valid), .rx_char(rx_char),
  .msg_ready(msg_ready), .msg_valid(msg_valid), .msg_code(msg_code),
  .msg_count(msg_count), .param_changed(param_changed), .xmit_differs(xmit_differs),
  .params_dirty(params_dirty), .load_factory(load_factory), .reload_flash(reload_flash),
  .mode_req(mode_req), .flash_wr(flash_wr), .flash_ack(flash_ack),
  .flash_err(flash_err), .save_count_init(save_count_init));

// *** verif/tb_svc_exit_restore.sv ***
`timescale 1ns/1ps
module tb_svc_exit_restore;
  import svc_cmd_pkg::*;
  localparam int H = 20;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_char = 8'h00;
  logic param_changed = 1'b0;
  logic xmit_differs = 1'b0;
  logic slow = 1'b0;
  logic fail = 1'b0;
  logic [15:0] save_count_init = 16'h0000;
  logic msg_ready, msg_valid, params_dirty, load_factory, reload_flash;
  logic flash_wr, flash_ack, flash_err;
  logic [15:0] msg_count, cnt_seen;
  msg_t msg_code;
  mode_req_t mode_req, mode_seen;
  int err_total = 0;
  int num_checks = 0;
  int n_load, n_reload, n_wr, n_mode;

  always #20 clk = ~clk;

  svc_exit_restore #(.HOLD(H)) i_svc_exit_restore (.clk(clk), .resetn(resetn),
    .rx_valid(rx_valid), .rx_char(rx_char), .msg_ready(msg_ready), .msg_valid(msg_valid),
    .msg_code(msg_code), .msg_count(msg_count), .param_changed(param_changed),
    .xmit_differs(xmit_differs), .params_dirty(params_dirty), .load_factory(load_factory),
    .reload_flash(reload_flash), .mode_req(mode_req), .flash_wr(flash_wr),
    .flash_ack(flash_ack), .flash_err(flash_err), .save_count_init(save_count_init));

  host_term_model i_host_term_model (.clk(clk), .msg_valid(msg_valid), .msg_code(msg_code),
    .flash_wr(flash_wr), .slow(slow), .fail(fail), .msg_ready(msg_ready),
    .flash_ack(flash_ack), .flash_err(flash_err));

  // Tally pulses so scenarios judge them after the fact
  always @(posedge clk)
  begin
    n_load <= n_load + int'(load_factory);
    n_reload <= n_reload + int'(reload_flash);
    n_wr <= n_wr + int'(flash_wr);
    if (mode_req != MODE_NONE)
    begin
      n_mode <= n_mode + 1;
      mode_seen <= mode_req;
    end
    if (msg_valid && msg_ready && msg_code == MSG_APPLIED_SAVED)
      cnt_seen <= msg_count;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Fresh start per scenario; counters cleared off the edge
  task automatic rst(input logic dirty, input logic [15:0] cnt, input logic xd, input logic fl);
    @(posedge clk);
    resetn <= 1'b0;
    save_count_init <= cnt;
    xmit_differs <= xd;
    fail <= fl;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    param_changed <= dirty;
    @(posedge clk);
    param_changed <= 1'b0;
    @(negedge clk);
    n_load = 0;
    n_reload = 0;
    n_wr = 0;
    n_mode = 0;
    mode_seen = MODE_NONE;
    i_host_term_model.got_q.delete();
    chk(16'(params_dirty), 16'(dirty));
  endtask : rst

  task automatic send(input string s);
    for (int k = 0; k < s.len(); k++)
    begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_char <= s[k];
      @(posedge clk);
      rx_valid <= 1'b0;
    end
  endtask : send

  task automatic expm(input msg_t m);
    int k;
    k = 0;
    while (i_host_term_model.got_q.size() == 0 && k < 200)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 200)
    begin
      err_total++;
      conclude();
    end
    chk(16'(i_host_term_model.got_q.pop_front()), 16'(m));
  endtask : expm

  // Clean exits report first, then switch after the hold
  task automatic t_exit_clean();
    int k;
    rst(1'b0, 16'h0000, 1'b0, 1'b0);
    send("x n\015");
    expm(MSG_RET_NORMAL);
    k = 0;
    while (n_mode == 0 && k < 60)
    begin
      @(negedge clk);
      k++;
    end
    chk(16'(k >= H - 2 && k <= H + 3), 16'h0001);
    chk(16'(mode_seen), 16'(MODE_NORMAL));
    chk(16'(n_reload), 16'h0000);
    rst(1'b0, 16'h0000, 1'b0, 1'b0);
    send("x i\015");
    expm(MSG_RET_INIT);
    repeat (H + 6) @(negedge clk);
    chk(16'(mode_seen), 16'(MODE_INIT));
    chk(16'(n_reload), 16'h0001);
    $display("test exit_clean done");
  endtask : t_exit_clean

  // Upper-case targets skip prompt and hold even when dirty
  task automatic t_exit_fast();
    rst(1'b1, 16'h0000, 1'b0, 1'b0);
    send("x N\015");
    repeat (4) @(negedge clk);
    chk(16'(mode_seen), 16'(MODE_NORMAL));
    chk(16'(i_host_term_model.got_q.size()), 16'h0000);
    rst(1'b1, 16'h0000, 1'b0, 1'b0);
    send("x I\015");
    repeat (4) @(negedge clk);
    chk(16'(mode_seen), 16'(MODE_INIT));
    chk(16'(n_reload), 16'h0001);
    $display("test exit_fast done");
  endtask : t_exit_fast

  // Dirty exit confirmed through a stalling host
  task automatic t_exit_yes();
    rst(1'b1, 16'h0000, 1'b0, 1'b0);
    slow <= 1'b1;
    send("x n\015");
    expm(MSG_ASK_EXIT);
    chk(16'(n_mode), 16'h0000);
    send("Y\015");
    expm(MSG_RET_NORMAL);
    repeat (H + 6) @(negedge clk);
    chk(16'(mode_seen), 16'(MODE_NORMAL));
    slow <= 1'b0;
    $display("test exit_yes done");
  endtask : t_exit_yes

  // Declined and malformed answers keep service mode
  task automatic t_exit_no();
    rst(1'b1, 16'h0000, 1'b0, 1'b0);
    send("x i\015");
    expm(MSG_ASK_EXIT);
    send("N\015");
    expm(MSG_PROMPT);
    send("x n\015");
    expm(MSG_ASK_EXIT);
    send("n\015");
    expm(MSG_E003);
    expm(MSG_PROMPT);
    repeat (H + 6) @(negedge clk);
    chk(16'(n_mode + n_reload), 16'h0000);
    $display("test exit_no done");
  endtask : t_exit_no

  // Bad command lines, each followed by a prompt
  task automatic t_errors();
    string c[6] = '{"q\015", "x\015", "x,n\015", "x nn\015", "x q\015", "z q\015"};
    msg_t m[6] = '{MSG_E001, MSG_E002, MSG_E002, MSG_E002, MSG_E003, MSG_E002};
    rst(1'b0, 16'h0000, 1'b0, 1'b0);
    for (int k = 0; k < 6; k++)
    begin
      send(c[k]);
      expm(m[k]);
      expm(MSG_PROMPT);
    end
    chk(16'(n_mode + n_load + n_wr), 16'h0000);
    $display("test errors done");
  endtask : t_errors

  // Restore without save, then a declined restore
  task automatic t_restore_plain();
    rst(1'b0, 16'h0000, 1'b0, 1'b0);
    send("z\015");
    expm(MSG_ASK_RESTORE);
    chk(16'(n_load), 16'h0000);
    send("Y\015");
    expm(MSG_APPLIED);
    expm(MSG_PROMPT);
    chk(16'(n_load), 16'h0001);
    chk(16'(n_wr), 16'h0000);
    chk(16'(params_dirty), 16'h0001);
    send("z\015");
    expm(MSG_ASK_RESTORE);
    send("N\015");
    expm(MSG_ABORTED);
    expm(MSG_PROMPT);
    chk(16'(n_load), 16'h0001);
    $display("test restore_plain done");
  endtask : t_restore_plain

  // Saving restores: over limit, at limit, and a failed write
  task automatic t_restore_save();
    rst(1'b1, 16'h03E9, 1'b1, 1'b0);
    send("z s\015");
    expm(MSG_ASK_RESTORE);
    send("Y\015");
    expm(MSG_ASK_XMIT);
    send("Y\015");
    expm(MSG_APPLIED_SAVED);
    chk(cnt_seen, 16'h03EA);
    expm(MSG_E004);
    expm(MSG_PROMPT);
    chk(16'(n_wr), 16'h0001);
    chk(16'(params_dirty), 16'h0000);
    rst(1'b0, 16'h03E8, 1'b0, 1'b0);
    send("z ,s\015");
    expm(MSG_ASK_RESTORE);
    send("Y\015");
    expm(MSG_APPLIED_SAVED);
    chk(cnt_seen, 16'h03E9);
    expm(MSG_PROMPT);
    rst(1'b0, 16'h0000, 1'b0, 1'b1);
    send("z s\015");
    expm(MSG_ASK_RESTORE);
    send("Y\015");
    expm(MSG_E005);
    expm(MSG_PROMPT);
    $display("test restore_save done");
  endtask : t_restore_save

  initial
  begin
    t_exit_clean();
    t_exit_fast();
    t_exit_yes();
    t_exit_no();
    t_errors();
    t_restore_plain();
    t_restore_save();
    conclude();
  end
endmodule : tb_svc_exit_restore
